// *** hw/lldc_defines.svh ***
// constants for the dram command and mode block
`ifndef LLDC_DEFINES_SVH
`define LLDC_DEFINES_SVH
`define LLDC_ADDR_W 22
`define LLDC_MODE_W 18
`define LLDC_BANKS 8
`define LLDC_ROWS_W 14
`define LLDC_DATA_W 18
`define LLDC_MODE_RST 18'h0_0000
`define LLDC_CFG_LSB 0
`define LLDC_BL_LSB 3
`define LLDC_LOOP_BIT 7
`define LLDC_IMP_BIT 8
`define LLDC_TERM_BIT 9
`define LLDC_LOCK_CYC 11'h400
`define LLDC_CAL_PERIOD 16'h0400
`define LLDC_BL2 2'h0
`define LLDC_BL4 2'h1
`define LLDC_BL8 2'h2
`define LLDC_IMP_NOMINAL 6'h32
`endif

// *** hw/lldc_pkg.sv ***
// types shared by the dram command and mode block
package lldc_pkg;
  typedef enum logic [4:0] {
    LLDC_CMD_NOP = 5'b0_0001,
    LLDC_CMD_MODE = 5'b0_0010,
    LLDC_CMD_READ = 5'b0_0100,
    LLDC_CMD_WRITE = 5'b0_1000,
    LLDC_CMD_REFRESH = 5'b1_0000
  } lldc_cmd_e;
endpackage

// *** hw/lldc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module lldc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // asynchronous input and synchronised output
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1; // first stage, read only by stage two

  // two flops in series, nothing taps the first
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // lldc_sync

// *** hw/lldc_odt.sv ***
// termination control for data and write-mask pins
`timescale 1ns/1ns
module lldc_odt (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // controls
  input wire logic term_on,
  input wire logic data_driving,
  // termination enables
  output logic data_term,
  output logic mask_term
);
  // data pins lose termination while driving; mask never drives
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_term <= 1'b0;
      mask_term <= 1'b0;
    end
    else
    begin
      data_term <= term_on && !data_driving; // R12
      mask_term <= term_on; // R13
    end
  end
endmodule // lldc_odt

// *** hw/lldc_ctrl.sv ***
// command decode, mode register and option control of the low latency dram
//
// Notes on behaviour
// (R1) controller holds address low in dummy loads
// (R2) valid power-up load keeps A10-A17 low
// (R3) controller resets loop on clock change
// (R4) controller refreshes all eight banks after load
// (R5) controller waits row cycle after refresh
// (R6) mode bit 7 enables the delay loop
// (R7) controller waits 1024 cycles before read
// (R8) loop reset: low, recover, high, wait
// (R9) bit 8 high: periodic external impedance sampling
// (R10) bit 8 low: internal reference, nominal 50 ohm
// (R11) bit 9 terminates data and mask only
// (R12) driving data pin drops its termination
// (R13) write-mask termination always on when enabled
// (R14) only listed commands valid, sampled at edge
// (R15) nop and deselect leave operations running
// (R16) mode load stores address bits 0-17
// (R17) controller loads mode only when idle
// (R18) read or write bursts to selected bank
// (R19) write-mask high discards that data beat
// (R20) refresh uses internal row counter per bank
// (R21) each refresh needs its own command
// (R22) write and refresh selects sampled with select
// (R23) write latency is read latency plus one
// (R24) decode select, write and refresh pins
//
`timescale 1ns/1ns
`include "lldc_defines.svh"
module lldc_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link clock pin, sampled by core_clk
  input wire logic ck_pin,
  // command pins, active low
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [`LLDC_ADDR_W-1:0] addr,
  input wire logic [2:0] bank_select,
  // write data path
  input wire logic [`LLDC_DATA_W-1:0] wr_data,
  input wire logic write_mask,
  // impedance ball comparator level
  input wire logic impedance_ball,
  // array-side command outputs
  output lldc_pkg::lldc_cmd_e cmd,
  output logic [2:0] cmd_bank,
  output logic [`LLDC_ADDR_W-1:0] cmd_addr,
  output logic [`LLDC_ROWS_W-1:0] refresh_row,
  output logic illegal_cmd,
  // write beat to array
  output logic wr_beat_valid,
  output logic [`LLDC_DATA_W-1:0] wr_beat_data,
  output logic [2:0] wr_beat_bank,
  // read data state
  output logic read_valid_flag,
  output logic data_driving,
  // mode outputs
  output logic [`LLDC_MODE_W-1:0] mode_reg,
  output logic loop_enable,
  output logic loop_locked,
  output logic [3:0] read_latency,
  output logic [3:0] write_latency,
  output logic [5:0] drive_impedance,
  output logic impedance_sample,
  output logic data_term,
  output logic mask_term
);
  import lldc_pkg::*;

  // synchronised pins
  logic ck_s; // link clock level
  logic ck_d; // previous clock level
  logic cs_n_s;
  logic we_n_s;
  logic ref_n_s;
  logic mask_s;
  logic zq_s;
  logic [`LLDC_ADDR_W-1:0] addr_s;
  logic [2:0] bank_s;
  logic [`LLDC_DATA_W-1:0] data_s;
  logic ck_rise; // true clock rise detected
  lldc_cmd_e next_cmd; // decoded command
  logic [`LLDC_ROWS_W-1:0] row_ctr [`LLDC_BANKS]; // per-bank refresh rows
  logic [10:0] lock_cnt; // loop lock wait counter
  logic [15:0] cal_cnt; // impedance sample period
  logic [3:0] wr_wait; // cycles to first write beat
  logic [3:0] rd_wait; // cycles to first read beat
  logic [3:0] wr_left; // write burst cycles left
  logic [3:0] rd_left; // read burst cycles left
  logic [2:0] wr_bank_q; // bank of pending write
  logic [5:0] zq_acc; // sampled impedance code

  // latency from configuration field, write is one longer
  function automatic logic [3:0] rl_of(input logic [2:0] cfg);
    case (cfg)
      3'h0: rl_of = 4'h4;
      3'h1: rl_of = 4'h6;
      3'h2: rl_of = 4'h8;
      3'h3: rl_of = 4'h3;
      default: rl_of = 4'h5;
    endcase
  endfunction

  // beats per burst in clock cycles (two beats per cycle)
  function automatic logic [3:0] bl_cycles(input logic [1:0] bl);
    case (bl)
      `LLDC_BL2: bl_cycles = 4'h1;
      `LLDC_BL4: bl_cycles = 4'h2;
      default: bl_cycles = 4'h4;
    endcase
  endfunction

  // all pins cross into core_clk before use
  lldc_sync #(.W(1)) u_sync_ck (
    .core_clk(core_clk), .rst_n(rst_n), .async_in(ck_pin), .sync_out(ck_s));
  lldc_sync #(.W(`LLDC_ADDR_W + 3 + 3 + 2 + `LLDC_DATA_W)) u_sync_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({addr, bank_select, cs_n, we_n, ref_n, write_mask, impedance_ball, wr_data}),
    .sync_out({addr_s, bank_s, cs_n_s, we_n_s, ref_n_s, mask_s, zq_s, data_s}));

  // termination switching lives in its own module
  lldc_odt u_odt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .term_on(mode_reg[`LLDC_TERM_BIT]), // R11
    .data_driving(data_driving),
    .data_term(data_term),
    .mask_term(mask_term));

  // edge finder on synchronised link clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ck_d <= 1'b0;
    else
      ck_d <= ck_s;
  end
  assign ck_rise = ck_s && !ck_d; // R14

  // command decode from select, write and refresh pins
  always_comb
  begin
    if (!ck_rise || cs_n_s)
      next_cmd = LLDC_CMD_NOP; // R15
    else if (!we_n_s && !ref_n_s)
      next_cmd = LLDC_CMD_MODE; // R24
    else if (we_n_s && ref_n_s)
      next_cmd = LLDC_CMD_READ; // R24
    else if (!we_n_s)
      next_cmd = LLDC_CMD_WRITE; // R24
    else
      next_cmd = LLDC_CMD_REFRESH; // R22
  end

  // registered command to the array, one cycle per clock rise
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd <= LLDC_CMD_NOP;
      cmd_bank <= 3'h0;
      cmd_addr <= '0;
      illegal_cmd <= 1'b0;
    end
    else
    begin
      cmd <= next_cmd; // R14
      cmd_bank <= bank_s; // R18
      cmd_addr <= addr_s; // R18
      // all four pin codes are listed, so none is illegal today
      illegal_cmd <= 1'b0;
    end
  end

  // mode register load from address bits 0-17
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= `LLDC_MODE_RST;
    else if (next_cmd == LLDC_CMD_MODE)
      mode_reg <= addr_s[`LLDC_MODE_W-1:0]; // R16
  end

  // latencies follow configuration field
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_latency <= 4'h4;
      write_latency <= 4'h5;
    end
    else
    begin
      read_latency <= rl_of(mode_reg[`LLDC_CFG_LSB +: 3]);
      write_latency <= rl_of(mode_reg[`LLDC_CFG_LSB +: 3]) + 4'h1; // R23
    end
  end

  // delay loop enable and lock wait, counted in link clock rises
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop_enable <= 1'b0;
      loop_locked <= 1'b0;
      lock_cnt <= 11'h000;
    end
    else
    begin
      loop_enable <= mode_reg[`LLDC_LOOP_BIT]; // R6
      if (!mode_reg[`LLDC_LOOP_BIT])
      begin
        // bit low turns the loop off and restarts lock
        loop_locked <= 1'b0;
        lock_cnt <= 11'h000;
      end
      else if (ck_rise && lock_cnt != `LLDC_LOCK_CYC)
        lock_cnt <= lock_cnt + 11'h001;
      else if (lock_cnt == `LLDC_LOCK_CYC)
        loop_locked <= 1'b1; // R6
    end
  end

  // impedance: periodic external sampling or fixed nominal
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_cnt <= 16'h0000;
      impedance_sample <= 1'b0;
      zq_acc <= `LLDC_IMP_NOMINAL;
      drive_impedance <= `LLDC_IMP_NOMINAL;
    end
    else if (mode_reg[`LLDC_IMP_BIT])
    begin
      // background update, no effect on command timing
      impedance_sample <= (cal_cnt == `LLDC_CAL_PERIOD); // R9
      if (cal_cnt == `LLDC_CAL_PERIOD)
      begin
        cal_cnt <= 16'h0000;
        drive_impedance <= zq_acc; // R9
      end
      else
        cal_cnt <= cal_cnt + 16'h0001;
      // crude step tracking toward comparator level
      if (zq_s && zq_acc != 6'h3f)
        zq_acc <= zq_acc + 6'h01;
      else if (!zq_s && zq_acc != 6'h00)
        zq_acc <= zq_acc - 6'h01;
    end
    else
    begin
      // internal reference, no sampling, drive held at fixed nominal
      cal_cnt <= 16'h0000;
      impedance_sample <= 1'b0;
      drive_impedance <= `LLDC_IMP_NOMINAL; // R10
    end
  end

  // per-bank refresh row counters, address pins ignored
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `LLDC_BANKS; i++)
        row_ctr[i] <= '0;
      refresh_row <= '0;
    end
    else if (next_cmd == LLDC_CMD_REFRESH)
    begin
      refresh_row <= row_ctr[bank_s]; // R20
      row_ctr[bank_s] <= row_ctr[bank_s] + 14'h0001; // R20
    end
  end

  // write burst timing: data after write latency, mask gates beats
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_wait <= 4'h0;
      wr_left <= 4'h0;
      wr_bank_q <= 3'h0;
      wr_beat_valid <= 1'b0;
      wr_beat_data <= '0;
      wr_beat_bank <= 3'h0;
    end
    else
    begin
      wr_beat_valid <= 1'b0;
      if (next_cmd == LLDC_CMD_WRITE)
      begin
        wr_wait <= write_latency - 4'h1; // R23 first beat lands on rise WL
        wr_left <= bl_cycles(mode_reg[`LLDC_BL_LSB +: 2]);
        wr_bank_q <= bank_s; // R18
      end
      else if (ck_rise && wr_wait != 4'h0)
        wr_wait <= wr_wait - 4'h1;
      else if (ck_rise && wr_left != 4'h0)
      begin
        wr_left <= wr_left - 4'h1;
        // masked beat is simply not presented to the array
        wr_beat_valid <= !mask_s; // R19
        wr_beat_data <= data_s;
        wr_beat_bank <= wr_bank_q;
      end
    end
  end

  // read burst timing drives data valid and driving state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_wait <= 4'h0;
      rd_left <= 4'h0;
      read_valid_flag <= 1'b0;
      data_driving <= 1'b0;
    end
    else
    begin
      if (next_cmd == LLDC_CMD_READ)
      begin
        // back to back reads restart the count, cutting off the burst in progress
        rd_wait <= read_latency;
        rd_left <= bl_cycles(mode_reg[`LLDC_BL_LSB +: 2]);
      end
      else if (ck_rise && rd_wait != 4'h0)
        rd_wait <= rd_wait - 4'h1;
      else if (ck_rise && rd_left != 4'h0)
        rd_left <= rd_left - 4'h1;
      read_valid_flag <= (rd_wait == 4'h0) && (rd_left != 4'h0);
      data_driving <= (rd_wait == 4'h0) && (rd_left != 4'h0); // R12
    end
  end
endmodule // lldc_ctrl

// *** dv/lldc_ctrl_props.sv ***
// assertion checker for the dram command and mode block
`timescale 1ns/1ns
`include "lldc_defines.svh"
module lldc_ctrl_props
  import lldc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched outputs
  input lldc_pkg::lldc_cmd_e cmd,
  input wire logic illegal_cmd,
  input wire logic [`LLDC_MODE_W-1:0] mode_reg,
  input wire logic loop_enable,
  input wire logic [3:0] read_latency,
  input wire logic [3:0] write_latency,
  input wire logic data_driving,
  input wire logic [5:0] drive_impedance,
  input wire logic impedance_sample,
  input wire logic data_term,
  input wire logic mask_term
);
  // one clock domain, so one clocking for all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_cmd_onehot: assert property ($onehot(cmd))
    else $error("cmd not one-hot");
  chk_no_illegal: assert property (!illegal_cmd)
    else $error("illegal flag raised");
  chk_lat_pair: assert property (write_latency == read_latency + 4'h1)
    else $error("write latency not read plus one");
  // mode only moves with a decoded load
  chk_load_only: assert property ($changed(mode_reg) |-> cmd == LLDC_CMD_MODE)
    else $error("mode changed without load");
  chk_loop_on: assert property (mode_reg[7] && $past(mode_reg[7]) |-> loop_enable)
    else $error("loop not enabled");
  chk_mask_term: assert property (mode_reg[9] && $past(mode_reg[9]) |-> mask_term)
    else $error("mask termination dropped");
  chk_term_off: assert property (!mode_reg[9] && $past(!mode_reg[9]) |-> !data_term && !mask_term)
    else $error("termination on while disabled");
  // registered: term follows driving one cycle late
  chk_data_drop: assert property (data_driving && $past(data_driving) |-> !data_term)
    else $error("termination on while driving");
  chk_data_back: assert property (mode_reg[9] && $past(mode_reg[9]) && !$past(data_driving)
    |-> data_term)
    else $error("termination not restored");
  // internal reference gives the fixed nominal drive
  chk_imp_nominal: assert property (!$past(mode_reg[`LLDC_IMP_BIT])
    |-> drive_impedance == `LLDC_IMP_NOMINAL)
    else $error("impedance not nominal");
  chk_imp_sample: assert property (impedance_sample |-> $past(mode_reg[`LLDC_IMP_BIT]))
    else $error("impedance sampled while off");
endmodule // lldc_ctrl_props
bind lldc_ctrl lldc_ctrl_props i_props (.core_clk, .rst_n, .cmd, .illegal_cmd, .mode_reg,
  .loop_enable, .read_latency, .write_latency, .data_driving, .drive_impedance,
  .impedance_sample, .data_term, .mask_term);

// *** dv/lldc_ctl_model.sv ***
// controller model that frames commands on the link clock
`timescale 1ns/1ns
module lldc_ctl_model (
  // core clock for pacing
  input wire logic core_clk,
  // link clock and command pins
  output logic ck_pin,
  output logic cs_n,
  output logic we_n,
  output logic ref_n,
  output logic [21:0] addr,
  output logic [2:0] bank_select
);
  // idle: link clock parked low, chip deselected
  initial
  begin
    ck_pin = 1'b0;
    cs_n = 1'b1;
    we_n = 1'b1;
    ref_n = 1'b1;
    addr = 22'h00_0000;
    bank_select = 3'h0;
  end
  // one 160 ns link cycle; pins settle well before the rise
  task automatic frame(input logic c, w, r, input logic [21:0] a, input logic [2:0] b);
    @(posedge core_clk);
    cs_n <= c;
    we_n <= w;
    ref_n <= r;
    addr <= a;
    bank_select <= b;
    repeat (4) @(posedge core_clk);
    ck_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    ck_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // deselected pins toggle so no stale value looks valid
  task automatic nop(input int n);
    repeat (n) frame(1'b1, ~we_n, ~ref_n, ~addr, ~bank_select);
  endtask
  // power-up: dummy loads, valid load, a refresh per bank among nops
  task automatic power_up(input logic [21:0] mval);
    frame(1'b0, 1'b0, 1'b0, 22'h00_0000, 3'h0);
    frame(1'b0, 1'b0, 1'b0, 22'h00_0000, 3'h0);
    frame(1'b0, 1'b0, 1'b0, mval, 3'h0);
    for (int b = 0; b < 8; b++)
    begin
      frame(1'b0, 1'b1, 1'b0, 22'h00_0000, b[2:0]);
      nop(128);
    end
  endtask
endmodule // lldc_ctl_model

// *** dv/lldc_ctrl_tb.sv ***
// self-checking bench for the dram command and mode block
`timescale 1ns/1ns
module lldc_ctrl_tb;
  import lldc_pkg::*;
  // one table row: pins in, expectations out
  typedef struct {
    logic c, w, r, m;
    logic [21:0] a;
    logic [2:0] b;
    lldc_cmd_e e;
    logic [3:0] rl;
    int nb;
  } lldc_row_s;
  lldc_row_s rows [10];
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] wr_data = 18'h2_5a5a;
  logic write_mask = 1'b0;
  logic impedance_ball = 1'b0;
  logic ck_pin, cs_n, we_n, ref_n, wr_beat_valid, data_driving, loop_enable, loop_locked;
  logic impedance_sample, data_term, mask_term, read_valid_flag;
  logic [21:0] addr, cmd_addr, sadr;
  logic [13:0] refresh_row;
  time tcmd, tbeat;
  int nvld = 0;
  int ndrv = 0;
  logic [2:0] bank_select, cmd_bank, wr_beat_bank, sbank, bbank;
  logic [17:0] wr_beat_data, mode_reg, bdata, em;
  logic [3:0] read_latency, write_latency;
  logic [5:0] drive_impedance;
  lldc_cmd_e cmd, seen;
  int n_mismatch = 0;
  int checked = 0;
  int nbeat = 0;
  int nsamp = 0;

  always #5 core_clk = ~core_clk;

  lldc_ctl_model i_ctl (.core_clk, .ck_pin, .cs_n, .we_n, .ref_n, .addr, .bank_select);
  lldc_ctrl i_dut (.core_clk, .rst_n, .ck_pin, .cs_n, .we_n, .ref_n, .addr, .bank_select,
    .wr_data, .write_mask, .impedance_ball, .cmd, .cmd_bank, .cmd_addr, .refresh_row,
    .illegal_cmd(), .wr_beat_valid, .wr_beat_data, .wr_beat_bank, .read_valid_flag,
    .data_driving, .mode_reg, .loop_enable, .loop_locked, .read_latency, .write_latency,
    .drive_impedance, .impedance_sample, .data_term, .mask_term);

  // latch decoded commands, write beats and calibration pulses
  always @(posedge core_clk)
  begin
    if (cmd !== LLDC_CMD_NOP)
    begin
      seen <= cmd;
      sbank <= cmd_bank;
      sadr <= cmd_addr;
      tcmd <= $time;
    end
    // read burst length in core cycles
    if (read_valid_flag === 1'b1)
      nvld <= nvld + 1;
    if (data_driving === 1'b1)
      ndrv <= ndrv + 1;
    if (wr_beat_valid === 1'b1)
    begin
      nbeat <= nbeat + 1;
      tbeat <= $time;
      bdata <= wr_beat_data;
      bbank <= wr_beat_bank;
    end
    if (impedance_sample === 1'b1)
      nsamp <= nsamp + 1;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, well past the ~35k cycles of the tests
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial
  begin
    // loads first, while idle; nop row last looks like a load if select were ignored
    rows = '{'{0, 0, 0, 0, 22'h00_0380, 0, LLDC_CMD_MODE, 4, 0},
      '{0, 0, 0, 0, 22'h00_0381, 0, LLDC_CMD_MODE, 6, 0},
      '{0, 0, 0, 0, 22'h00_0382, 0, LLDC_CMD_MODE, 8, 0},
      '{0, 0, 0, 0, 22'h00_0383, 0, LLDC_CMD_MODE, 3, 0},
      '{0, 0, 0, 0, 22'h00_0384, 0, LLDC_CMD_MODE, 5, 0},
      '{0, 1, 1, 0, 22'h00_1234, 3, LLDC_CMD_READ, 5, 0},
      '{0, 0, 1, 0, 22'h00_0040, 5, LLDC_CMD_WRITE, 5, 1},
      '{0, 0, 1, 1, 22'h00_0044, 2, LLDC_CMD_WRITE, 5, 0},
      '{0, 1, 0, 0, 22'h3f_ffff, 7, LLDC_CMD_REFRESH, 5, 0},
      '{1, 0, 0, 0, 22'h00_0000, 1, LLDC_CMD_NOP, 5, 0}};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    i_ctl.power_up(22'h00_0280);
    chk(loop_locked, 1'b1);
    chk(mode_reg, 18'h0_0280);
    chk(drive_impedance, 6'h32);
    chk(data_term, 1'b1);
    chk(mask_term, 1'b1);
    impedance_ball <= 1'b1;
    nsamp = 0;
    foreach (rows[i])
    begin
      seen = LLDC_CMD_NOP;
      nbeat = 0;
      nvld = 0;
      ndrv = 0;
      write_mask <= rows[i].m;
      if (rows[i].e == LLDC_CMD_MODE)
        em = rows[i].a[17:0];
      i_ctl.frame(rows[i].c, rows[i].w, rows[i].r, rows[i].a, rows[i].b);
      i_ctl.nop(12);
      chk(seen, rows[i].e);
      if (rows[i].e != LLDC_CMD_NOP)
        chk(sbank, rows[i].b);
      if (rows[i].e == LLDC_CMD_READ || rows[i].e == LLDC_CMD_WRITE)
        chk(sadr, rows[i].a);
      // burst of two beats is one link cycle of 16 core cycles
      chk(nvld, (rows[i].e == LLDC_CMD_READ) ? 16 : 0);
      chk(ndrv, (rows[i].e == LLDC_CMD_READ) ? 16 : 0);
      chk(mode_reg, em);
      chk(read_latency, rows[i].rl);
      chk(write_latency, rows[i].rl + 4'h1);
      chk(nbeat, rows[i].nb);
      if (rows[i].nb > 0)
      begin
        chk({bbank, bdata}, {rows[i].b, wr_data});
        // first beat taken write latency link cycles after the command
        chk(tbeat - tcmd, 160 * (rows[i].rl + 1));
      end
      chk(data_term, 1'b1);
    end
    chk(nsamp > 0, 1'b1);
    // comparator held high, tracker saturates at the top code
    chk(drive_impedance, 6'h3f);
    // second refresh of bank 7 takes the next internal row
    chk(refresh_row, 14'h0001);
    // loop reset: bit low, recover, bit high, count lock
    i_ctl.frame(1'b0, 1'b0, 1'b0, 22'h00_0204, 3'h0);
    i_ctl.nop(2);
    chk(loop_enable, 1'b0);
    i_ctl.frame(1'b0, 1'b0, 1'b0, 22'h00_0284, 3'h0);
    i_ctl.nop(1000);
    chk(loop_locked, 1'b0);
    i_ctl.nop(24);
    chk(loop_locked, 1'b1);
    // reset in mid-run restores defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(cmd, LLDC_CMD_NOP);
    chk(mode_reg, 18'h0_0000);
    chk({read_latency, write_latency}, 8'h45);
    chk(drive_impedance, 6'h32);
    chk(loop_enable, 1'b0);
    // release again and load once more
    rst_n <= 1'b1;
    i_ctl.frame(1'b0, 1'b0, 1'b0, 22'h00_0200, 3'h0);
    i_ctl.nop(1);
    chk(mode_reg, 18'h0_0200);
    chk(data_term, 1'b1);
    tally_and_finish;
  end
endmodule // lldc_ctrl_tb
